//--- brl_pkg.sv
// constants and types shared by the bad-row bypass log design
package brl_pkg;

	localparam int unsigned BRL_NUM_REGS = 7;
	localparam int unsigned BRL_ADDR_W = 16;
	localparam int unsigned BRL_DATA_W = 32;
	localparam int unsigned BRL_ROW_W = 11;
	localparam int unsigned BRL_GRP_W = 3;

	// register offsets in the arbiter_config_space
	localparam logic [15:0] BANK0_BAD_ROW_LOG_3_OFS = 16'hb07c;
	localparam logic [15:0] BANK0_BAD_ROW_LOG_4_OFS = 16'hb080;
	localparam logic [15:0] BANK0_BAD_ROW_LOG_5_OFS = 16'hb084;
	localparam logic [15:0] BANK0_BAD_ROW_LOG_6_OFS = 16'hb088;
	localparam logic [15:0] BANK0_BAD_ROW_LOG_7_OFS = 16'hb08c;
	localparam logic [15:0] BANK1_BAD_ROW_LOG_0_OFS = 16'hb090;
	localparam logic [15:0] BANK1_BAD_ROW_LOG_1_OFS = 16'hb094;

	localparam logic [15:0] BRL_LOG_OFS [BRL_NUM_REGS] = '{
		BANK0_BAD_ROW_LOG_3_OFS,
		BANK0_BAD_ROW_LOG_4_OFS,
		BANK0_BAD_ROW_LOG_5_OFS,
		BANK0_BAD_ROW_LOG_6_OFS,
		BANK0_BAD_ROW_LOG_7_OFS,
		BANK1_BAD_ROW_LOG_0_OFS,
		BANK1_BAD_ROW_LOG_1_OFS
	};

	// field positions
	localparam int unsigned SECOND_ROW_MSB = 31;
	localparam int unsigned SECOND_ROW_LSB = 21;
	localparam int unsigned SECOND_VALID_BIT = 16;
	localparam int unsigned FIRST_ROW_MSB = 15;
	localparam int unsigned FIRST_ROW_LSB = 5;
	localparam int unsigned FIRST_VALID_BIT = 0;

	localparam logic [31:0] BRL_LOG_RESET = 32'h0000_0000;
	localparam logic [31:0] BRL_WRITE_MASK = 32'hffe1_ffe1;
	localparam logic [31:0] BRL_READ_VALUE = 32'h0000_0000;

	// significant row bits per subbank size
	localparam int unsigned BRL_ROW_W_4K = 10;
	localparam int unsigned BRL_ROW_W_LARGE = 11;
	localparam logic [10:0] BRL_ROW_MASK_4K = 11'h3ff;
	localparam logic [10:0] BRL_ROW_MASK_LARGE = 11'h7ff;

	typedef enum logic [3:0] {
		BRL_RET_IDLE = 4'h1,
		BRL_RET_SAVE = 4'h2,
		BRL_RET_HELD = 4'h4,
		BRL_RET_LOAD = 4'h8
	} brl_ret_state_t;

	typedef logic [31:0] brl_word_t;

endpackage

//--- brl_log_if.sv
// carrier of log contents between the log core, retention and match logic
`timescale 1ns/10ps
interface brl_log_if #(
	parameter int unsigned N = 7
);
	logic [31:0] log_q [N];
	logic [31:0] shadow_q [N];
	logic save_stb;

	modport owner (output log_q, output save_stb, input shadow_q);
	modport retain (input log_q, input save_stb, output shadow_q);
	modport match (input log_q);
endinterface

//--- brl_retention.sv
// retention copy of the log, kept on the always-on reset
`timescale 1ns/10ps
module brl_retention #(
	parameter int unsigned N = 7
) (
	input wire logic clock_i,
	input wire logic aon_rst_n_i,
	brl_log_if.retain log_if
);
	import brl_pkg::*;

	// not cleared by core reset so the log survives a power-down
	always_ff @(posedge clock_i or negedge aon_rst_n_i)
	begin
		if (!aon_rst_n_i)
		begin
			for (int i = 0; i < N; i++)
				log_if.shadow_q[i] <= BRL_LOG_RESET;
		end
		else if (log_if.save_stb)
		begin
			for (int i = 0; i < N; i++)
				log_if.shadow_q[i] <= log_if.log_q[i];
		end
	end
endmodule

//--- brl_match.sv
// per-group bad-row compare for the lookup port
`timescale 1ns/10ps
module brl_match #(
	parameter int unsigned N = 7
) (
	brl_log_if.match log_if,
	input wire logic [2:0] group_i,
	input wire logic [10:0] row_i,
	input wire logic large_subbank_i,
	output logic hit_o
);
	import brl_pkg::*;

	logic [N-1:0] grp_hit;
	logic [10:0] row_mask;

	if (N > 8)
	begin : g_chk_n
		$error("group select is three bits wide");
	end

	// 4k-row subbanks only decode ten bits
	assign row_mask = large_subbank_i ? BRL_ROW_MASK_LARGE : BRL_ROW_MASK_4K;

	for (genvar g = 0; g < N; g++)
	begin : g_grp
		logic [10:0] r0;
		logic [10:0] r1;
		logic h0;
		logic h1;
		assign r0 = log_if.log_q[g][FIRST_ROW_MSB:FIRST_ROW_LSB];
		assign r1 = log_if.log_q[g][SECOND_ROW_MSB:SECOND_ROW_LSB];
		assign h0 = log_if.log_q[g][FIRST_VALID_BIT] && ((r0 & row_mask) == (row_i & row_mask));
		assign h1 = log_if.log_q[g][SECOND_VALID_BIT] && ((r1 & row_mask) == (row_i & row_mask));
		assign grp_hit[g] = h0 || h1;
	end

	// out-of-range group never hits
	assign hit_o = (32'(group_i) < N) ? grp_hit[group_i] : 1'b0;
endmodule

//--- brl_top.sv
// bad-row bypass log: config registers, lookup port and retention sequencing
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - bits 31:21 hold the second entry row index, write-only, zero at reset.
// - bits 15:5 hold the first entry row index, write-only, zero at reset.
// - bit 16 is the second entry valid flag, write-only, zero at reset.
// - bit 0 is the first entry valid flag, write-only, zero at reset.
// - a valid entry makes its subbank group skip the logged row.
// - row index uses ten bits for 4K subbanks, eleven for larger.
// - a row field is the physical row where parity failed.
// - one register serves each 16KB subbank group.
// - log is saved and restored by hardware around deep power saving.
module brl_top #(
	parameter int unsigned NUM_REGS = brl_pkg::BRL_NUM_REGS
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic aon_arst_n_i,
	input wire logic cfg_req_i,
	input wire logic cfg_wr_i,
	input wire logic [brl_pkg::BRL_ADDR_W-1:0] cfg_addr_i,
	input wire logic [brl_pkg::BRL_DATA_W-1:0] cfg_wdata_i,
	output logic cfg_ack_o,
	output logic cfg_hit_o,
	output logic [brl_pkg::BRL_DATA_W-1:0] cfg_rdata_o,
	input wire logic lookup_req_i,
	input wire logic [brl_pkg::BRL_GRP_W-1:0] lookup_group_i,
	input wire logic [brl_pkg::BRL_ROW_W-1:0] lookup_row_i,
	input wire logic large_subbank_i,
	output logic lookup_ack_o,
	output logic bypass_row_o,
	input wire logic save_req_i,
	input wire logic restore_req_i,
	output logic save_done_o,
	output logic restore_done_o,
	output logic log_armed_o
);
	import brl_pkg::*;

	// refuse parameter values the fixed register layout cannot serve
	if (NUM_REGS != BRL_NUM_REGS)
	begin : g_chk_num
		$error("NUM_REGS must match the mapped register count");
	end

	if (NUM_REGS > 2 ** BRL_GRP_W)
	begin : g_chk_grp
		$error("lookup group select too narrow for NUM_REGS");
	end

	if (SECOND_ROW_MSB - SECOND_ROW_LSB + 1 != BRL_ROW_W)
	begin : g_chk_row1
		$error("second row field width differs from the row width");
	end

	if (FIRST_ROW_MSB - FIRST_ROW_LSB + 1 != BRL_ROW_W)
	begin : g_chk_row0
		$error("first row field width differs from the row width");
	end

	if (BRL_DATA_W != 32)
	begin : g_chk_data
		$error("log registers are 32 bits wide");
	end

	if (BRL_ROW_W_LARGE != BRL_ROW_W || BRL_ROW_W_4K >= BRL_ROW_W)
	begin : g_chk_mask
		$error("row widths per subbank size are inconsistent");
	end

	////////////////////////////////////////////////////////////////////////////
	// reset synchronisers
	logic rst_meta_ff;
	logic rst_n_ff;
	logic aon_meta_ff;
	logic aon_n_ff;

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	always_ff @(posedge clock_i or negedge aon_arst_n_i)
	begin
		if (!aon_arst_n_i)
		begin
			aon_meta_ff <= 1'b0;
			aon_n_ff <= 1'b0;
		end
		else
		begin
			aon_meta_ff <= 1'b1;
			aon_n_ff <= aon_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// address decode
	brl_log_if #(.N(NUM_REGS)) log_if ();

	logic [NUM_REGS-1:0] sel;
	logic any_sel;
	logic wr_stb;

	for (genvar r = 0; r < NUM_REGS; r++)
	begin : g_dec
		assign sel[r] = (cfg_addr_i == BRL_LOG_OFS[r]);
	end

	assign any_sel = |sel;
	assign wr_stb = cfg_req_i && cfg_wr_i && any_sel;

	////////////////////////////////////////////////////////////////////////////
	// retention sequencer
	brl_ret_state_t ret_state_ff;
	brl_ret_state_t nxt_ret_state;
	logic restore_stb;

	always_comb
	begin
		nxt_ret_state = ret_state_ff;
		case (ret_state_ff)
			BRL_RET_IDLE:
				if (save_req_i)
					nxt_ret_state = BRL_RET_SAVE;
			BRL_RET_SAVE:
				nxt_ret_state = BRL_RET_HELD;
			BRL_RET_HELD:
				if (restore_req_i && rst_n_ff)
					nxt_ret_state = BRL_RET_LOAD;
				else if (save_req_i)
					nxt_ret_state = BRL_RET_SAVE;
			BRL_RET_LOAD:
				nxt_ret_state = BRL_RET_IDLE;
			default:
				nxt_ret_state = BRL_RET_IDLE;
		endcase
	end

	// sequencer sits on the always-on reset so it remembers a pending restore
	always_ff @(posedge clock_i or negedge aon_n_ff)
	begin
		if (!aon_n_ff)
			ret_state_ff <= BRL_RET_IDLE;
		else
			ret_state_ff <= nxt_ret_state;
	end

	// a restore while the core is still in reset is refused: the load would be lost
	assign log_if.save_stb = (ret_state_ff == BRL_RET_SAVE);
	assign restore_stb = (ret_state_ff == BRL_RET_LOAD);

	always_ff @(posedge clock_i or negedge aon_n_ff)
	begin
		if (!aon_n_ff)
		begin
			save_done_o <= 1'b0;
			restore_done_o <= 1'b0;
		end
		else
		begin
			save_done_o <= log_if.save_stb;
			restore_done_o <= restore_stb;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// log storage: only the row and valid fields have flops
	logic [NUM_REGS-1:0] grp_armed;

	for (genvar r = 0; r < NUM_REGS; r++)
	begin : g_log
		logic [BRL_ROW_W-1:0] row1_ff;
		logic [BRL_ROW_W-1:0] row0_ff;
		logic vld1_ff;
		logic vld0_ff;
		logic load;
		brl_word_t src;
		brl_word_t word;

		// restore wins over a write landing in the same cycle
		assign load = restore_stb || (wr_stb && sel[r]);
		assign src = restore_stb ? log_if.shadow_q[r] : cfg_wdata_i;

		always_ff @(posedge clock_i or negedge rst_n_ff)
		begin
			if (!rst_n_ff)
				row1_ff <= BRL_LOG_RESET[SECOND_ROW_MSB:SECOND_ROW_LSB];
			else if (load)
				row1_ff <= src[SECOND_ROW_MSB:SECOND_ROW_LSB];
		end

		always_ff @(posedge clock_i or negedge rst_n_ff)
		begin
			if (!rst_n_ff)
				vld1_ff <= BRL_LOG_RESET[SECOND_VALID_BIT];
			else if (load)
				vld1_ff <= src[SECOND_VALID_BIT];
		end

		always_ff @(posedge clock_i or negedge rst_n_ff)
		begin
			if (!rst_n_ff)
				row0_ff <= BRL_LOG_RESET[FIRST_ROW_MSB:FIRST_ROW_LSB];
			else if (load)
				row0_ff <= src[FIRST_ROW_MSB:FIRST_ROW_LSB];
		end

		always_ff @(posedge clock_i or negedge rst_n_ff)
		begin
			if (!rst_n_ff)
				vld0_ff <= BRL_LOG_RESET[FIRST_VALID_BIT];
			else if (load)
				vld0_ff <= src[FIRST_VALID_BIT];
		end

		// reserved bits keep the reset pattern, so they never hold written data
		always_comb
		begin
			word = BRL_LOG_RESET;
			word[SECOND_ROW_MSB:SECOND_ROW_LSB] = row1_ff;
			word[SECOND_VALID_BIT] = vld1_ff;
			word[FIRST_ROW_MSB:FIRST_ROW_LSB] = row0_ff;
			word[FIRST_VALID_BIT] = vld0_ff;
		end

		assign log_if.log_q[r] = word;
		assign grp_armed[r] = vld0_ff || vld1_ff;
	end

	brl_retention #(.N(NUM_REGS)) u_retention (
		.clock_i(clock_i),
		.aon_rst_n_i(aon_n_ff),
		.log_if(log_if.retain)
	);

	////////////////////////////////////////////////////////////////////////////
	// config answer: one cycle after every request
	always_ff @(posedge clock_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			cfg_ack_o <= 1'b0;
			cfg_hit_o <= 1'b0;
			cfg_rdata_o <= BRL_READ_VALUE;
		end
		else
		begin
			cfg_ack_o <= cfg_req_i;
			cfg_hit_o <= cfg_req_i && any_sel;
			// entries are never readable back, mapped or not
			cfg_rdata_o <= BRL_READ_VALUE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bypass lookup
	logic hit;

	brl_match #(.N(NUM_REGS)) u_match (
		.log_if(log_if.match),
		.group_i(lookup_group_i),
		.row_i(lookup_row_i),
		.large_subbank_i(large_subbank_i),
		.hit_o(hit)
	);

	// lookups trust software to have loaded the log before cache traffic
	always_ff @(posedge clock_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			lookup_ack_o <= 1'b0;
			bypass_row_o <= 1'b0;
		end
		else
		begin
			lookup_ack_o <= lookup_req_i;
			bypass_row_o <= lookup_req_i && hit;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status for the cache: some entry is active
	always_ff @(posedge clock_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			log_armed_o <= 1'b0;
		else
			log_armed_o <= |grp_armed;
	end
endmodule

//--- brl_top_properties.sv
// port-level assertions for the bad-row bypass log
`timescale 1ns/10ps
module brl_top_properties (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic aon_arst_n_i,
	input wire logic cfg_req_i,
	input wire logic [15:0] cfg_addr_i,
	input wire logic cfg_ack_o,
	input wire logic cfg_hit_o,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic lookup_req_i,
	input wire logic [2:0] lookup_group_i,
	input wire logic lookup_ack_o,
	input wire logic bypass_row_o,
	input wire logic log_armed_o,
	input wire logic save_req_i,
	input wire logic restore_req_i,
	input wire logic save_done_o,
	input wire logic restore_done_o
);
	logic mapped;
	// word offsets only; byte lanes inside a word are not decoded
	assign mapped = cfg_addr_i >= 16'hb07c && cfg_addr_i <= 16'hb094 && cfg_addr_i[1:0] == 2'h0;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	////////////////////////////////////////////////////////////////////////////////
	chk_cfg_answer: assert property (cfg_req_i |=> cfg_ack_o && cfg_rdata_o == 32'h0)
		else $error("config answer missing or read data not zero");
	chk_map_hit: assert property (cfg_req_i && mapped |=> cfg_hit_o)
		else $error("mapped offset not decoded");
	chk_unmap_miss: assert property (cfg_req_i && !mapped |=> !cfg_hit_o)
		else $error("unmapped offset decoded");
	chk_lookup_answer: assert property (lookup_req_i |=> lookup_ack_o)
		else $error("lookup answer missing");
	chk_bypass_qualified: assert property (bypass_row_o |-> lookup_ack_o && $past(lookup_req_i))
		else $error("bypass without lookup");
	// armed status and bypass both reflect the log at the lookup edge
	chk_idle_no_bypass: assert property (lookup_req_i ##1 (!log_armed_o
		|| $past(lookup_group_i) == 3'h7) |-> !bypass_row_o)
		else $error("bypass with no valid entry");
	chk_save_timing: assert property (@(posedge clock_i) disable iff (!aon_arst_n_i)
		$rose(save_done_o) |-> $past(save_req_i, 2))
		else $error("save done without request");
	chk_restore_timing: assert property (@(posedge clock_i) disable iff (!aon_arst_n_i)
		$rose(restore_done_o) |-> $past(restore_req_i, 2))
		else $error("restore done without request");
	cov_bypass: cover property (bypass_row_o);
	cov_unmapped: cover property (cfg_ack_o && !cfg_hit_o);
	cov_restore: cover property (@(posedge clock_i) disable iff (!aon_arst_n_i) restore_done_o);
endmodule
bind brl_top brl_top_properties i_brl_top_properties (.clock_i(clock_i), .arst_n_i(arst_n_i),
	.aon_arst_n_i(aon_arst_n_i), .cfg_req_i(cfg_req_i), .cfg_addr_i(cfg_addr_i),
	.cfg_ack_o(cfg_ack_o), .cfg_hit_o(cfg_hit_o), .cfg_rdata_o(cfg_rdata_o),
	.lookup_req_i(lookup_req_i), .lookup_group_i(lookup_group_i), .lookup_ack_o(lookup_ack_o),
	.bypass_row_o(bypass_row_o), .log_armed_o(log_armed_o), .save_req_i(save_req_i),
	.restore_req_i(restore_req_i), .save_done_o(save_done_o), .restore_done_o(restore_done_o));

//--- tb_top.sv
// self-checking bench for the bad-row bypass log
`timescale 1ns/10ps
module tb_top;
	import brl_pkg::*;
	logic clock_i = 0, arst_n_i = 0, aon_arst_n_i = 0, cfg_req_i = 0, cfg_wr_i = 0;
	logic lookup_req_i = 0, large_subbank_i = 1, save_req_i = 0, restore_req_i = 0;
	logic [15:0] cfg_addr_i = '0;
	logic [31:0] cfg_wdata_i = '0;
	logic [2:0] lookup_group_i = '0;
	logic [10:0] lookup_row_i = '0, r0, r1;
	logic cfg_ack_o, cfg_hit_o, lookup_ack_o, bypass_row_o, save_done_o, restore_done_o;
	logic log_armed_o;
	logic [31:0] cfg_rdata_o;
	int failures = 0, n_compared = 0;
	always #5 clock_i = ~clock_i;
	brl_top i_brl_top (.clock_i(clock_i), .arst_n_i(arst_n_i), .aon_arst_n_i(aon_arst_n_i),
		.cfg_req_i(cfg_req_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
		.cfg_wdata_i(cfg_wdata_i), .cfg_ack_o(cfg_ack_o), .cfg_hit_o(cfg_hit_o),
		.cfg_rdata_o(cfg_rdata_o), .lookup_req_i(lookup_req_i), .lookup_group_i(lookup_group_i),
		.lookup_row_i(lookup_row_i), .large_subbank_i(large_subbank_i),
		.lookup_ack_o(lookup_ack_o), .bypass_row_o(bypass_row_o), .save_req_i(save_req_i),
		.restore_req_i(restore_req_i), .save_done_o(save_done_o),
		.restore_done_o(restore_done_o), .log_armed_o(log_armed_o));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d,
		input logic hit);
		@(negedge clock_i);
		{cfg_req_i, cfg_wr_i, cfg_addr_i, cfg_wdata_i} = {1'b1, wr, a, d};
		@(negedge clock_i);
		cfg_req_i = 0;
		check(cfg_ack_o, 1);
		check(cfg_hit_o, hit);
		check(cfg_rdata_o, 32'h0);
	endtask
	task automatic look(input logic [2:0] g, input logic [10:0] r, input logic lg, input logic exp);
		@(negedge clock_i);
		{lookup_req_i, lookup_group_i, lookup_row_i, large_subbank_i} = {1'b1, g, r, lg};
		@(negedge clock_i);
		lookup_req_i = 0;
		check(lookup_ack_o, 1);
		check(bypass_row_o, exp);
	endtask
	// core reset only; the retention copy must survive it
	task automatic core_reset;
		@(negedge clock_i);
		arst_n_i = 0;
		repeat (2) @(negedge clock_i);
		arst_n_i = 1;
		repeat (3) @(negedge clock_i);
	endtask
	initial
	begin
		repeat (20000) @(posedge clock_i);
		failures++;
		wrap_up();
	end
	initial
	begin
		repeat (8) @(negedge clock_i);
		aon_arst_n_i = 1;
		core_reset();
		for (int i = 0; i < 7; i++)
		begin
			access(0, BRL_LOG_OFS[i], 32'h0, 1);
			look(3'(i), 11'h000, 1, 0);
		end
		access(1, BRL_LOG_OFS[0], 32'h001e_001e, 1);
		access(1, 16'hb078, 32'hffff_ffff, 0);
		access(1, 16'hb098, 32'hffff_ffff, 0);
		check(log_armed_o, 0);
		for (int i = 0; i < 7; i++)
		begin
			r0 = 11'h7f0 + 11'(i);
			r1 = 11'h011 + 11'(i);
			access(1, BRL_LOG_OFS[i], {r1, 4'h0, 1'b1, r0, 4'h0, 1'b1}, 1);
		end
		check(log_armed_o, 1);
		for (int i = 0; i < 7; i++)
		begin
			r0 = 11'h7f0 + 11'(i);
			r1 = 11'h011 + 11'(i);
			look(3'(i), r0, 1, 1);
			look(3'(i), r1, 1, 1);
			look(3'(i), r0 ^ 11'h001, 1, 0);
			look(3'((i + 1) % 7), r1, 1, 0);
			look(3'(i), r0 & 11'h3ff, 0, 1);
			look(3'(i), r0 & 11'h3ff, 1, 0);
		end
		look(3'h7, 11'h7f0, 1, 0);
		access(1, BRL_LOG_OFS[0], {11'h011, 4'h0, 1'b1, 11'h7f0, 4'h0, 1'b0}, 1);
		look(3'h0, 11'h7f0, 1, 0);
		look(3'h0, 11'h011, 1, 1);
		access(1, BRL_LOG_OFS[0], {11'h011, 4'h0, 1'b0, 11'h7f0, 4'h0, 1'b1}, 1);
		look(3'h0, 11'h011, 1, 0);
		look(3'h0, 11'h7f0, 1, 1);
		@(negedge clock_i);
		save_req_i = 1;
		@(negedge clock_i);
		save_req_i = 0;
		check(save_done_o, 0);
		@(negedge clock_i);
		check(save_done_o, 1);
		@(negedge clock_i);
		check(save_done_o, 0);
		core_reset();
		check(log_armed_o, 0);
		look(3'h1, 11'h7f1, 1, 0);
		@(negedge clock_i);
		restore_req_i = 1;
		@(negedge clock_i);
		restore_req_i = 0;
		check(restore_done_o, 0);
		@(negedge clock_i);
		check(restore_done_o, 1);
		@(negedge clock_i);
		check(restore_done_o, 0);
		check(log_armed_o, 1);
		look(3'h1, 11'h7f1, 1, 1);
		look(3'h6, 11'h017, 1, 1);
		wrap_up();
	end
endmodule
